// [core/ssc_pkg.sv]
// Purpose: shared constants and types for the synthesizer serial control port
// Assumes: two-wire bus sampled by the system clock
// Notes: byte layouts of the four control bytes and the status byte
package ssc_pkg;
  // ==========================================================
  // address and byte classification
  localparam logic [4:0] SSC_ADDR_PREFIX = 5'h18; // fixed upper five address bits
  localparam int SSC_CLASS_BIT = 7;
  localparam int SSC_DIR_BIT = 0;
  // ==========================================================
  // divider and control field positions
  localparam int SSC_N16_BIT = 6;
  localparam int SSC_N15_BIT = 5;
  localparam int SSC_PRESC_BIT = 4;
  localparam int SSC_BITS_PER_BYTE = 8;
  localparam logic [3:0] SSC_BIT_LAST = 4'h7;
  // ==========================================================
  // reset value of control byte 5, test select codes and converter limit
  localparam logic [7:0] SSC_CTRL2_RESET = 8'h14;
  localparam logic [2:0] SSC_TEST_SINK = 3'h0;
  localparam logic [2:0] SSC_TEST_SOURCE = 3'h1;
  localparam logic [2:0] SSC_TEST_PUMP_OFF = 3'h2;
  localparam logic [2:0] SSC_TEST_HALF_DIV = 3'h3;
  localparam logic [2:0] SSC_ADC_MAX = 3'h4;

  // which data byte is expected next
  typedef enum logic [4:0] {
    SSC_EXP_CLASS = 5'h01,
    SSC_EXP_DIV_LO = 5'h02,
    SSC_EXP_CTRL2 = 5'h04,
    SSC_EXP_DONE = 5'h08,
    SSC_EXP_IGNORE = 5'h10
  } ssc_expect_type;

  // decoded control settings driven to the analog blocks
  typedef struct packed {
    logic [16:0] main_divider_ratio;
    logic prescaler_on;
    logic [3:0] ref_divider_select;
    logic [1:0] pump_current_select;
    logic ref_out_enable;
    logic ref_out_select;
    logic test_mode;
    logic [2:0] test_select;
  } ssc_ctrl_type;

  // limit converter code to its legal five levels
  function automatic logic [2:0] ssc_clip_adc(input logic [2:0] code);
    ssc_clip_adc = (code > SSC_ADC_MAX) ? SSC_ADC_MAX : code;
  endfunction : ssc_clip_adc
endpackage : ssc_pkg

// [core/ssc_serial_port.sv]
// Purpose: two-wire target port of a frequency synthesizer
// Assumes: clk_sys far faster than the serial clock; reset_n from supply monitor
// Notes: bus lines sampled and edge-detected on clk_sys
`timescale 1ns/10ps
`default_nettype none
import ssc_pkg::*;
module ssc_serial_port (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] addr_level_pin,
  input wire logic loop_locked,
  input wire logic [2:0] converter_code,
  input wire logic half_div_signal,
  input wire logic [2:0] port_pin_in,
  output logic [3:0] port_out,
  output logic [3:0] port_oe_n,
  output ssc_ctrl_type ctrl
);
  // ==========================================================
  // synchronised bus lines and pins
  logic [6:0] sync_q;
  ssc_sync #(.WIDTH(7)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in({scl_in, sda_in, addr_level_pin, port_pin_in}),
    .sync_out(sync_q)
  );
  logic scl_s, sda_s;
  logic [1:0] addr_sel;
  logic [2:0] port_lvl;
  assign scl_s = sync_q[6];
  assign sda_s = sync_q[5];
  assign addr_sel = sync_q[4:3];
  assign port_lvl = sync_q[2:0];

  // ==========================================================
  // state
  logic scl_d_reg, sda_d_reg;
  logic active_reg, active_next;
  logic addr_phase_reg, addr_phase_next;
  logic read_reg, read_next;
  logic ack_slot_reg, ack_slot_next;
  logic drive_reg, drive_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  ssc_expect_type exp_reg, exp_next;
  logic [7:0] div_hi_reg, div_hi_next;
  logic [7:0] div_lo_reg, div_lo_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [16:0] ratio_reg, ratio_next;
  logic div_pend_reg, div_pend_next;
  logic got_ctrl1_reg, got_ctrl1_next;
  logic por_flag_reg, por_flag_next;
  logic out_valid_reg, out_valid_next;

  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // status byte assembly
  logic lock_view;
  logic [7:0] status_byte;
  logic test_on;
  assign test_on = ~ctrl2_reg[5] & ctrl2_reg[4];
  always_comb begin
    lock_view = loop_locked;
    if (test_on) begin
      unique case (ctrl2_reg[2:0])
        SSC_TEST_SINK: lock_view = 1'b1;
        SSC_TEST_SOURCE, SSC_TEST_PUMP_OFF: lock_view = 1'b0;
        default: lock_view = loop_locked;
      endcase
    end
  end
  assign status_byte = {por_flag_reg, lock_view, port_lvl, ssc_clip_adc(converter_code)};

  // ==========================================================
  // next state of the serial engine and register file
  always_comb begin
    active_next = active_reg;
    addr_phase_next = addr_phase_reg;
    read_next = read_reg;
    ack_slot_next = ack_slot_reg;
    drive_next = drive_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    exp_next = exp_reg;
    div_hi_next = div_hi_reg;
    div_lo_next = div_lo_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    ratio_next = ratio_reg;
    div_pend_next = div_pend_reg;
    got_ctrl1_next = got_ctrl1_reg;
    por_flag_next = por_flag_reg;
    out_valid_next = out_valid_reg;
    if (stop_cond) begin
      // stop ends a partial sequence and applies the ratio
      if (div_pend_reg || got_ctrl1_reg) begin
        ratio_next = {ctrl1_reg[SSC_N16_BIT], ctrl1_reg[SSC_N15_BIT],
                      div_hi_reg[6:0], div_lo_reg};
      end
      div_pend_next = 1'b0;
      got_ctrl1_next = 1'b0;
      active_next = 1'b0;
      drive_next = 1'b0;
      ack_slot_next = 1'b0;
    end else if (start_cond) begin
      active_next = 1'b1;
      addr_phase_next = 1'b1;
      read_next = 1'b0;
      ack_slot_next = 1'b0;
      drive_next = 1'b0;
      bit_cnt_next = '0;
      exp_next = SSC_EXP_CLASS;
    end else if (active_reg && scl_rise) begin
      if (ack_slot_reg) begin
        // controller ack sampled in read
        if (read_reg && sda_s) begin
          active_next = 1'b0;
          por_flag_next = 1'b0;
        end
      end else begin
        shift_next = {shift_reg[6:0], sda_s};
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end
    end else if (active_reg && scl_fall) begin
      if (ack_slot_reg) begin
        ack_slot_next = 1'b0;
        bit_cnt_next = '0;
        if (read_reg) begin
          tx_next = status_byte;
          drive_next = ~status_byte[SSC_BITS_PER_BYTE-1];
        end else begin
          drive_next = 1'b0;
        end
      end else if (bit_cnt_reg == 4'(SSC_BITS_PER_BYTE)) begin
        ack_slot_next = 1'b1;
        drive_next = 1'b0;
        if (addr_phase_reg) begin
          addr_phase_next = 1'b0;
          if (shift_reg[7:3] == SSC_ADDR_PREFIX && shift_reg[2:1] == addr_sel) begin
            read_next = shift_reg[SSC_DIR_BIT];
            drive_next = 1'b1;
          end else begin
            active_next = 1'b0;
            ack_slot_next = 1'b0;
          end
        end else if (read_reg) begin
          drive_next = 1'b0;
        end else begin
          drive_next = 1'b1;
          unique case (exp_reg)
            SSC_EXP_CLASS, SSC_EXP_DONE, SSC_EXP_IGNORE: begin
              if (!shift_reg[SSC_CLASS_BIT]) begin
                if (div_pend_reg && exp_reg != SSC_EXP_DONE) begin
                  ratio_next = ratio_reg;
                end
                div_hi_next = shift_reg;
                div_pend_next = 1'b1;
                exp_next = SSC_EXP_DIV_LO;
              end else begin
                ctrl1_next = shift_reg;
                got_ctrl1_next = 1'b1;
                exp_next = SSC_EXP_CTRL2;
              end
            end
            SSC_EXP_DIV_LO: begin
              div_lo_next = shift_reg;
              exp_next = got_ctrl1_reg ? SSC_EXP_DONE : SSC_EXP_CLASS;
            end
            SSC_EXP_CTRL2: begin
              ctrl2_next = shift_reg;
              exp_next = div_pend_reg ? SSC_EXP_DONE : SSC_EXP_CLASS;
            end
          endcase
          // full set of bytes 2 to 5 in either order
          if (exp_next == SSC_EXP_DONE) begin
            ratio_next = {ctrl1_next[SSC_N16_BIT], ctrl1_next[SSC_N15_BIT],
                          div_hi_next[6:0], div_lo_next};
            div_pend_next = 1'b0;
            got_ctrl1_next = 1'b0;
          end
        end
      end else if (read_reg && !addr_phase_reg && !ack_slot_reg) begin
        // shift next status bit onto the line
        tx_next = {tx_reg[6:0], 1'b0};
        drive_next = ~tx_reg[SSC_BITS_PER_BYTE-2];
      end
    end
    if (active_reg && !out_valid_reg && !read_reg && exp_next == SSC_EXP_CLASS
        && bit_cnt_reg == 4'(SSC_BITS_PER_BYTE) && scl_fall && !addr_phase_reg) begin
      out_valid_next = 1'b1;
    end
    if (ctrl2_next != ctrl2_reg) begin
      out_valid_next = 1'b1;
    end
  end

  // ==========================================================
  // register the engine
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      active_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      read_reg <= 1'b0;
      ack_slot_reg <= 1'b0;
      drive_reg <= 1'b0;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      tx_reg <= '0;
      exp_reg <= SSC_EXP_CLASS;
      div_hi_reg <= '0;
      div_lo_reg <= '0;
      ctrl1_reg <= '0;
      ctrl2_reg <= SSC_CTRL2_RESET;
      ratio_reg <= '0;
      div_pend_reg <= 1'b0;
      got_ctrl1_reg <= 1'b0;
      por_flag_reg <= 1'b1;
      out_valid_reg <= 1'b0;
    end else if (clk_en) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      active_reg <= active_next;
      addr_phase_reg <= addr_phase_next;
      read_reg <= read_next;
      ack_slot_reg <= ack_slot_next;
      drive_reg <= drive_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      exp_reg <= exp_next;
      div_hi_reg <= div_hi_next;
      div_lo_reg <= div_lo_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      ratio_reg <= ratio_next;
      div_pend_reg <= div_pend_next;
      got_ctrl1_reg <= got_ctrl1_next;
      por_flag_reg <= por_flag_next;
      out_valid_reg <= out_valid_next;
    end
  end

  // ==========================================================
  // open-drain data line: pull low when drive_reg set
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_reg;

  // ports: open collector, released until first program after reset
  logic p0_val;
  assign p0_val = (test_on && ctrl2_reg[2:0] == SSC_TEST_HALF_DIV)
                  ? half_div_signal : ctrl2_reg[0];
  assign port_out = 4'h0;
  assign port_oe_n = out_valid_reg ? ~{ctrl2_reg[3:1], p0_val} : 4'hF;

  // decoded settings
  assign ctrl.main_divider_ratio = ratio_reg;
  assign ctrl.prescaler_on = ctrl1_reg[SSC_PRESC_BIT];
  assign ctrl.ref_divider_select = ctrl1_reg[3:0];
  assign ctrl.pump_current_select = ctrl2_reg[7:6];
  assign ctrl.ref_out_enable = ctrl2_reg[5];
  assign ctrl.ref_out_select = ctrl2_reg[4];
  assign ctrl.test_mode = test_on;
  assign ctrl.test_select = ctrl2_reg[2:0];
endmodule : ssc_serial_port
`default_nettype wire

// [core/ssc_sync.sv]
// Purpose: two-flop synchroniser for external levels
// Assumes: inputs asynchronous to clk_sys
// Notes: first stage read only by the second
`timescale 1ns/10ps
`default_nettype none
module ssc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  // ==========================================================
  // two stage capture
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end else if (clk_en) begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_out = stage2_reg;
endmodule : ssc_sync
`default_nettype wire

// [tb/ssc_bus_ctrl.sv]
// Purpose: two-wire bus controller model
// Assumes: clock phases of 4 clk_sys, line pulled up
// Notes: data moves 1 clk after the clock falls
`timescale 1ns/10ps
`default_nettype none
module ssc_bus_ctrl (
  input wire logic clk_sys,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic drv;
  // open-drain line with pull-up
  assign sda = drv & sda_oe_n;
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  // one clock pulse, line sampled mid-high
  task automatic bitx(input logic b, output logic r);
    wt(1);
    drv <= b;
    wt(3);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
  endtask : bitx
  task automatic start;
    wt(1);
    drv <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(4);
    drv <= 1'b0;
    wt(4);
    scl <= 1'b0;
  endtask : start
  task automatic stop;
    wt(1);
    drv <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(4);
    drv <= 1'b1;
    wt(4);
  endtask : stop
  task automatic put(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, ack);
  endtask : put
  task automatic get(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(last, r);
  endtask : get
endmodule : ssc_bus_ctrl
`default_nettype wire

// [tb/ssc_serial_port_asserts.sv]
// Purpose: port checks for the serial control port
// Assumes: ports of ssc_serial_port only
// Notes: bound after the module
`timescale 1ns/10ps
`default_nettype none
module ssc_serial_port_asserts import ssc_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [1:0] addr_level_pin,
  input wire logic loop_locked,
  input wire logic [2:0] converter_code,
  input wire logic half_div_signal,
  input wire logic [2:0] port_pin_in,
  input wire logic [3:0] port_out,
  input wire logic [3:0] port_oe_n,
  input wire ssc_ctrl_type ctrl
);
  // ==========================================================
  // assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_byte5_defaults: assert property ($rose(reset_n) |-> ctrl.pump_current_select == 2'h0
    && !ctrl.ref_out_enable && ctrl.ref_out_select && ctrl.test_select[2])
    else $error("byte 5 defaults wrong");
  chk_ports_released: assert property ($rose(reset_n) |-> (port_oe_n == 4'hF) [*8])
    else $error("ports driven after reset");
  chk_sda_idle_reset: assert property ($rose(reset_n) |-> sda_oe_n [*3])
    else $error("data line pulled after reset");
  chk_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_port_open_drain: assert property (port_out == 4'h0)
    else $error("port driven high");
  chk_test_decode: assert property (ctrl.test_mode == (!ctrl.ref_out_enable && ctrl.ref_out_select))
    else $error("test mode decode wrong");
  chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  chk_port0_follow: assert property (($changed(half_div_signal) && ctrl.test_mode
    && ctrl.test_select == 3'h3) |-> ##[1:5] (port_oe_n[0] == !half_div_signal))
    else $error("port 0 not following divider");
  // main scenarios
  cov_ack: cover property ($fell(sda_oe_n));
  cov_ratio: cover property ($changed(ctrl.main_divider_ratio));
  cov_half_div: cover property (ctrl.test_mode && ctrl.test_select == 3'h3);
endmodule : ssc_serial_port_asserts
bind ssc_serial_port ssc_serial_port_asserts ssc_serial_port_asserts_i (.clk_sys(clk_sys),
  .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .addr_level_pin(addr_level_pin), .loop_locked(loop_locked),
  .converter_code(converter_code), .half_div_signal(half_div_signal),
  .port_pin_in(port_pin_in), .port_out(port_out), .port_oe_n(port_oe_n), .ctrl(ctrl));
`default_nettype wire

// [tb/ssc_serial_port_bench.sv]
// Purpose: bench for the serial control port
// Assumes: address pin level 2, controller model on the bus
// Notes: serial clock period 400 ns
`timescale 1ns/10ps
`default_nettype none
module ssc_serial_port_bench import ssc_pkg::*; ;
  logic clk_sys = 1'b0, reset_n = 1'b0, clk_en = 1'b1, loop_locked = 1'b1, half_div_signal = 1'b0;
  logic [1:0] addr_level_pin = 2'h2;
  logic [2:0] converter_code = 3'h7, port_pin_in = 3'h5;
  logic sda_out, sda_oe_n;
  logic [3:0] port_out, port_oe_n;
  wire scl, sda;
  ssc_ctrl_type ctrl;
  int n_mismatch = 0, n_tests = 0;
  always #25 clk_sys = ~clk_sys;
  ssc_serial_port ssc_serial_port_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_level_pin(addr_level_pin), .loop_locked(loop_locked), .converter_code(converter_code),
    .half_div_signal(half_div_signal), .port_pin_in(port_pin_in), .port_out(port_out),
    .port_oe_n(port_oe_n), .ctrl(ctrl));
  ssc_bus_ctrl ssc_bus_ctrl_i (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [29:0] e, input logic [29:0] s);
    n_tests++;
    if (e !== s) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [29:0] ex(logic [16:0] n, logic pe, logic [3:0] rs, logic [7:0] b);
    return {n, pe, rs, b[7:6], b[5], b[4], !b[5] && b[4], b[2:0]};
  endfunction : ex
  task automatic send(input logic [7:0] ad, input logic [31:0] d, input int n, input logic fin);
    logic a;
    ssc_bus_ctrl_i.start;
    ssc_bus_ctrl_i.put(ad, a);
    chk("addr ack", {29'h0, ad != 8'hC4}, {29'h0, a});
    for (int k = 0; k < n; k++) begin
      ssc_bus_ctrl_i.put(d[31-8*k -: 8], a);
      chk("data ack", 30'h0, {29'h0, a});
    end
    if (fin) ssc_bus_ctrl_i.stop;
  endtask : send
  task automatic rd(input logic [7:0] e);
    logic a;
    logic [7:0] v;
    ssc_bus_ctrl_i.start;
    ssc_bus_ctrl_i.put(8'hC5, a);
    chk("read ack", 30'h0, {29'h0, a});
    ssc_bus_ctrl_i.get(1'b1, v);
    ssc_bus_ctrl_i.stop;
    chk("status", {22'h0, e}, {22'h0, v});
  endtask : rd
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // ==========================================================
  // watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    results;
  end
  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(8'hEC);
    rd(8'h6C);
    send(8'hC4, 32'h1234C568, 4, 1'b1);
    chk("ctrl", ex(17'h11234, 1'b0, 4'h5, 8'h68), ctrl);
    send(8'hC0, 32'h0, 0, 1'b1);
    send(8'hC4, 32'h01FF02EE, 4, 1'b0);
    chk("ctrl", ex(17'h11234, 1'b0, 4'h5, 8'h68), ctrl);
    ssc_bus_ctrl_i.stop;
    chk("ctrl", ex(17'h102EE, 1'b0, 4'h5, 8'h68), ctrl);
    send(8'hC4, 32'hB5000000, 1, 1'b1);
    chk("ctrl", ex(17'h082EE, 1'b1, 4'h5, 8'h68), ctrl);
    converter_code <= 3'h3;
    for (int k = 0; k < 4; k++) begin
      loop_locked <= (k != 0);
      send(8'hC4, {8'hB5, 5'h02, k[2:0], 16'h0}, 2, 1'b1);
      chk("ctrl", ex(17'h082EE, 1'b1, 4'h5, {5'h02, k[2:0]}), ctrl);
      if (k < 3) rd({1'b0, k == 0, 3'h5, 3'h3});
      else repeat (2) begin
        half_div_signal <= !half_div_signal;
        repeat (10) @(posedge clk_sys);
        chk("ports", {26'h0, 3'h6, !half_div_signal}, {26'h0, port_oe_n});
      end
    end
    results;
  end
endmodule : ssc_serial_port_bench
`default_nettype wire
